//--- core/gha_core.sv
// Purpose: Input line events into an event table, plus host register access
// Assumes: Host is the bus master and drives the link clock
// Notes:   Link clock must stay high long enough for a read fetch

// Overview of operation
// - Lines selectively enrolled into event table
// - Line events raise the common event flag
// - Event codes 97 to 114, one per line
// - Active-high line: rising edge records press
// - Active-low line: falling edge records press
// - After press, arm for opposite level
// - Opposite level records a release event
// - Bit 7 set for press, clear for release
// - No enrolled line events while keypad locked
// - Unlimited data bytes in one write
// - Read returns register chosen by command byte
// - Write data commits at acknowledge clock rise
// - Enroll bit one includes line, zero excludes
// - Sense bit one rising, zero falling trigger
// - Write one clears flag, releases interrupt
module gha_core (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire logic                     scl_clk,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic [gha_pkg::LINES-1:0] general_input_line,
  input  wire logic                     keypad_locked,
  output logic                          int_n_out,
  output logic                          int_n_oe
);

  // Lowest set index of a request vector
  function automatic logic [4:0] first_set(
    input logic [gha_pkg::LINES-1:0] v
  );
    first_set = 5'h00;
    for (int i = gha_pkg::LINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction : first_set

  // Offset falls inside a three-byte bank
  function automatic logic in_bank(
    input logic [7:0] a,
    input logic [7:0] base
  );
    in_bank = (a >= base) && (a < base + gha_pkg::BANK_LEN);
  endfunction : in_bank

  // ---------------- Link clock domain ----------------
  logic               start_tog;   // Flips on each start condition
  logic               start_seen;  // Last start handled by the link
  gha_pkg::gha_state_t state;      // Byte phase
  logic [3:0]         cnt;         // Bits taken in this byte
  logic [7:0]         sh;          // Receive shift register
  logic [7:0]         ptr;         // Register pointer
  logic [7:0]         tx;          // Transmit shift register
  logic               wr_tog;      // Write request toggle
  logic               rd_tog;      // Read fetch toggle
  gha_pkg::gha_wreq_t wreq;        // Held write request

  // ---------------- Core clock domain ----------------
  logic [gha_pkg::LINES-1:0] line_s;   // Synchronised input lines
  logic [1:0]                tog_s;    // Synchronised toggles
  logic [1:0]                tog_d;    // Toggles one cycle later
  logic [2:0][7:0]           enroll;   // Event table enrolment
  logic [2:0][7:0]           sense;    // Trigger sense per line
  logic [gha_pkg::LINES-1:0] held;     // Line armed for release
  logic [7:0][7:0]           table_q;  // Event table storage
  gha_pkg::gha_idx_t         wp;       // Table write index
  gha_pkg::gha_idx_t         rp;       // Table read index
  gha_pkg::gha_cnt_t         count;    // Events waiting
  logic                      evt_flag; // Sticky event flag
  logic [7:0]                rd_word;  // Byte fetched for the link

  // Start condition: data falls while the clock is high. A start
  // cannot be seen on the link clock, so the data line clocks it.
  always_ff @(negedge sda_in or negedge rstn) begin
    if (!rstn) begin
      start_tog <= 1'b0;
    end else if (scl_clk) begin
      start_tog <= ~start_tog;
    end
  end

  // Decodes on the link side
  wire new_frame = start_tog != start_seen;
  wire at_ack    = cnt == gha_pkg::BIT_ACK;
  wire addr_hit  = sh[7:1] == gha_pkg::DEV_ADDR;
  wire rw_read   = sh[0];
  wire ack_due   = at_ack && (state == gha_pkg::ST_CMD ||
                   state == gha_pkg::ST_WDATA ||
                   (state == gha_pkg::ST_ADDR && addr_hit));

  // Rising link edge: sample data, count bits, act at acknowledge
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      start_seen <= 1'b0;
      state      <= gha_pkg::ST_IDLE;
      cnt        <= gha_pkg::BIT_ZERO;
      sh         <= gha_pkg::BYTE_ZERO;
      ptr        <= gha_pkg::BYTE_ZERO;
      wr_tog     <= 1'b0;
      rd_tog     <= 1'b0;
      wreq       <= '0;
    end else begin
      start_seen <= start_tog;
      if (new_frame) begin
        // A start, repeated or not, restarts the address phase
        state <= gha_pkg::ST_ADDR;
        cnt   <= gha_pkg::BIT_ONE;
        sh    <= {7'h00, sda_in};
      end else if (state == gha_pkg::ST_IDLE) begin
        // Ignore traffic for other devices
        cnt <= gha_pkg::BIT_ZERO;
      end else if (!at_ack) begin
        cnt <= 4'(cnt + gha_pkg::BIT_ONE);
        sh  <= {sh[6:0], sda_in};
      end else begin
        cnt <= gha_pkg::BIT_ZERO;
        case (state)
          gha_pkg::ST_ADDR: begin
            if (!addr_hit) begin
              state <= gha_pkg::ST_IDLE;
            end else if (rw_read) begin
              state  <= gha_pkg::ST_RDATA;
              rd_tog <= ~rd_tog;
            end else begin
              state <= gha_pkg::ST_CMD;
            end
          end
          gha_pkg::ST_CMD: begin
            ptr   <= sh;
            state <= gha_pkg::ST_WDATA;
          end
          gha_pkg::ST_WDATA: begin
            // Stays here for as many bytes as the host sends
            wreq   <= '{addr: ptr, data: sh};
            wr_tog <= ~wr_tog;
            ptr    <= 8'(ptr + 8'h01);
          end
          gha_pkg::ST_RDATA: begin
            if (sda_in) begin
              state <= gha_pkg::ST_IDLE;           // Host declined more
            end else begin
              ptr    <= 8'(ptr + 8'h01);
              rd_tog <= ~rd_tog;
            end
          end
          default: begin
            state <= gha_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Falling link edge: drive acknowledge or read data, open drain
  always_ff @(negedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe <= 1'b0;
      tx     <= gha_pkg::BYTE_ZERO;
    end else if (ack_due) begin
      sda_oe <= 1'b1;
    end else if (state == gha_pkg::ST_RDATA &&
                 cnt == gha_pkg::BIT_ZERO) begin
      // Fetched byte must be ready by now; see the limitation above
      tx     <= {rd_word[6:0], 1'b0};
      sda_oe <= ~rd_word[7];
    end else if (state == gha_pkg::ST_RDATA && !at_ack) begin
      tx     <= {tx[6:0], 1'b0};
      sda_oe <= ~tx[7];
    end else begin
      sda_oe <= 1'b0;
    end
  end

  // Open-drain levels only ever pull low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sda_out   <= 1'b0;
      int_n_out <= 1'b0;
    end else begin
      sda_out   <= 1'b0;
      int_n_out <= 1'b0;
    end
  end

  // ---------------- Crossings into the core ----------------
  gha_sync #(.W(gha_pkg::LINES)) u_line_sync (
    .clk  (sys_clk),
    .rstn (rstn),
    .d    (general_input_line),
    .q    (line_s)
  );

  gha_sync #(.W(2)) u_tog_sync (
    .clk  (sys_clk),
    .rstn (rstn),
    .d    ({rd_tog, wr_tog}),
    .q    (tog_s)
  );

  // Toggle edge detect, after the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tog_d <= 2'h0;
    end else begin
      tog_d <= tog_s;
    end
  end

  // Link words are stable for many link bits after each toggle
  wire       wr_fire = tog_s[0] ^ tog_d[0];
  wire       rd_fire = tog_s[1] ^ tog_d[1];
  wire [7:0] rd_addr = ptr;

  // Line bank registers, one byte each, unused bits held at zero
  for (genvar g = 0; g < 3; g++) begin : g_bank
    wire hit_en = wr_fire && wreq.addr == 8'(gha_pkg::REG_ENROLL + g);
    wire hit_sn = wr_fire && wreq.addr == 8'(gha_pkg::REG_SENSE + g);
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        enroll[g] <= gha_pkg::BYTE_ZERO;
        sense[g]  <= gha_pkg::BYTE_ZERO;
      end else begin
        if (hit_en) begin
          enroll[g] <= wreq.data & gha_pkg::LINE_MASK[8*g +: 8];
        end
        if (hit_sn) begin
          sense[g] <= wreq.data & gha_pkg::LINE_MASK[8*g +: 8];
        end
      end
    end
  end

  // ---------------- Event detection ----------------
  wire [23:0] enroll_v = enroll;
  wire [23:0] sense_v  = sense;
  // Enrolled and not locked lines are tracked
  wire [gha_pkg::LINES-1:0] track =
    enroll_v[gha_pkg::LINES-1:0] &
    {gha_pkg::LINES{~keypad_locked}};
  // Line sits at its trigger level
  wire [gha_pkg::LINES-1:0] active =
    ~(line_s ^ sense_v[gha_pkg::LINES-1:0]);
  // Level differs from what is armed: press or release due
  wire [gha_pkg::LINES-1:0] req   = track & (active ^ held);
  wire [4:0]                sel   = first_set(req);
  wire                      full  = count == gha_pkg::DEPTH;
  // A full table holds the event back until space returns
  wire                      evt_push = (|req) && !full;
  wire gha_pkg::gha_event_t evt = '{
    press: ~held[sel],
    code:  7'(gha_pkg::CODE_BASE + 7'(sel))
  };
  wire [gha_pkg::LINES-1:0] sel_bit =
    gha_pkg::LINES'(1) << sel;
  // Dropped lines forget their armed state
  wire [gha_pkg::LINES-1:0] next_held =
    (held & track) ^ (evt_push ? sel_bit : '0);

  // One event per cycle, lowest line first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  // ---------------- Event table ----------------
  wire pop = rd_fire && rd_addr == gha_pkg::REG_EVENT &&
             count != 4'h0;

  // Index wraps at the depth, which is a power of two
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      table_q <= '0;
      wp      <= '0;
      rp      <= '0;
      count   <= '0;
    end else begin
      if (evt_push) begin
        table_q[wp] <= evt;
        wp          <= gha_pkg::gha_idx_t'(wp + gha_pkg::IDX_ONE);
      end
      if (pop) begin
        rp <= gha_pkg::gha_idx_t'(rp + gha_pkg::IDX_ONE);
      end
      count <= gha_pkg::gha_cnt_t'(count +
               gha_pkg::gha_cnt_t'(evt_push) -
               gha_pkg::gha_cnt_t'(pop));
    end
  end

  // ---------------- Status and interrupt ----------------
  wire clr_evt = wr_fire && wreq.addr == gha_pkg::REG_STATUS &&
                 wreq.data[gha_pkg::STAT_EVT];

  // New event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evt_flag <= 1'b0;
    end else begin
      evt_flag <= evt_push || (evt_flag && !clr_evt);
    end
  end

  assign int_n_oe = evt_flag;

  // ---------------- Read fetch ----------------
  wire [1:0] en_i = 2'(rd_addr - gha_pkg::REG_ENROLL);
  wire [1:0] sn_i = 2'(rd_addr - gha_pkg::REG_SENSE);
  wire [7:0] rd_val =
    (rd_addr == gha_pkg::REG_STATUS) ? {7'h00, evt_flag} :
    (rd_addr == gha_pkg::REG_COUNT)  ? {4'h0, count} :
    (rd_addr == gha_pkg::REG_EVENT)  ?
      ((count != 4'h0) ? table_q[rp] : gha_pkg::BYTE_ZERO) :
    in_bank(rd_addr, gha_pkg::REG_ENROLL) ? enroll[en_i] :
    in_bank(rd_addr, gha_pkg::REG_SENSE)  ? sense[sn_i] :
    gha_pkg::BYTE_ZERO;

  // Fetched byte stays put until the next fetch
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_word <= gha_pkg::BYTE_ZERO;
    end else if (rd_fire) begin
      rd_word <= rd_val;
    end
  end

  // ---------------- Checks ----------------
  property p_code_range;
    @(posedge sys_clk) disable iff (!rstn)
    evt_push |-> (evt.code >= gha_pkg::CODE_BASE &&
                  evt.code <= gha_pkg::CODE_LAST);
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("event code out of range");

  property p_lock;
    @(posedge sys_clk) disable iff (!rstn)
    keypad_locked |=> $stable(count) || $fell(count != 4'h0) ||
                      (count < $past(count));
  endproperty
  a_lock: assert property (p_lock)
    else $error("event recorded while locked");

  property p_enroll;
    @(posedge sys_clk) disable iff (!rstn)
    evt_push |-> enroll_v[sel] && !keypad_locked;
  endproperty
  a_enroll: assert property (p_enroll)
    else $error("event from line not enrolled");

  property p_press_bit;
    @(posedge sys_clk) disable iff (!rstn)
    evt_push |-> (evt.press == (line_s[sel] == sense_v[sel]));
  endproperty
  a_press_bit: assert property (p_press_bit)
    else $error("press bit does not match level");

  property p_arm;
    @(posedge sys_clk) disable iff (!rstn)
    (evt_push && evt.press) |=> held[$past(sel)];
  endproperty
  a_arm: assert property (p_arm)
    else $error("line not armed after press");

  property p_flag_set;
    @(posedge sys_clk) disable iff (!rstn)
    evt_push |=> evt_flag && int_n_oe;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event did not raise interrupt");

  property p_flag_clr;
    @(posedge sys_clk) disable iff (!rstn)
    (clr_evt && !evt_push) |=> !int_n_oe;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("interrupt not released by clear");

  property p_count;
    @(posedge sys_clk) disable iff (!rstn)
    (evt_push && !pop) |=> count == $past(count) + 4'h1;
  endproperty
  a_count: assert property (p_count)
    else $error("event count did not step");

  property p_ack_own;
    @(posedge scl_clk) disable iff (!rstn)
    (at_ack && state == gha_pkg::ST_ADDR && !new_frame) |->
      (sda_oe == addr_hit);
  endproperty
  a_ack_own: assert property (p_ack_own)
    else $error("address acknowledge wrong");

  property p_wr_step;
    @(posedge scl_clk) disable iff (!rstn)
    (at_ack && state == gha_pkg::ST_WDATA && !new_frame) |=>
      (ptr == 8'($past(ptr) + 8'h01)) && (wr_tog != $past(wr_tog));
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("write not committed or pointer stuck");

  c_press:   cover property (@(posedge sys_clk) evt_push && evt.press);
  c_release: cover property (@(posedge sys_clk) evt_push && !evt.press);
  c_clear:   cover property (@(posedge sys_clk) clr_evt && evt_flag);
  c_read:    cover property (@(posedge sys_clk) pop);

endmodule : gha_core

//--- core/gha_sync.sv
// Purpose: Two-stage synchroniser for levels and toggles
// Assumes: Each bit changes slowly compared with clk
// Notes:   Stage one is read by stage two only
module gha_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;  // First stage, may go metastable

  // Plain shift through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : gha_sync

//--- inc/gha_pkg.sv
// Purpose: Shared constants and types for the input event and host access
// Assumes: Register offsets and device bus address are local choices
// Notes:   Widths are fixed; nothing here is meant to be overridden
package gha_pkg;

  // Input lines that may join the event table
  localparam int LINES = 18;

  // Event codes for line 0 and the last line
  localparam logic [6:0] CODE_BASE = 7'h61;
  localparam logic [6:0] CODE_LAST = 7'h72;

  // Seven-bit bus address answered by the device (arbitrary value)
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  // Register offsets selected by the command byte
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_COUNT  = 8'h03;
  localparam logic [7:0] REG_EVENT  = 8'h04;
  localparam logic [7:0] REG_ENROLL = 8'h20;
  localparam logic [7:0] REG_SENSE  = 8'h26;
  localparam logic [7:0] BANK_LEN   = 8'h03;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // Writable bits of the three-byte line banks
  localparam logic [23:0] LINE_MASK = 24'h03ffff;

  // Event flag position in the status register
  localparam int STAT_EVT = 0;

  // Event table storage
  typedef logic [2:0] gha_idx_t;
  typedef logic [3:0] gha_cnt_t;
  localparam gha_cnt_t DEPTH   = 4'h8;
  localparam gha_cnt_t CNT_ONE = 4'h1;
  localparam gha_idx_t IDX_ONE = 3'h1;

  // Bit counter marks inside one byte on the link
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE  = 4'h1;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  // Link-side byte phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA
  } gha_state_t;

  // Register write carried from the link to the core clock
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } gha_wreq_t;

  // One entry of the event table
  typedef struct packed {
    logic       press;
    logic [6:0] code;
  } gha_event_t;

endpackage : gha_pkg

//--- tb/gha_host.sv
// Purpose: Host model that masters the serial link, open-drain style
// Assumes: Link clock stands high outside frames; SDA has a pull-up
// Notes:   Slot is 32 ns, low 6 ns then high 26 ns for the read fetch
module gha_host (
  output logic      scl_clk,
  output logic      host_pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: clock high, data released
  initial begin
    scl_clk   = 1'b1;
    host_pull = 1'b0;
  end

  // One bit slot; data changes only while the clock is low
  task automatic bit_slot(input logic b, output logic s);
    scl_clk = 1'b0;
    #3 host_pull = ~b;
    #3 scl_clk = 1'b1;
    #13 s = sda;
    #13;
  endtask : bit_slot

  // Data edge while clock high: (0,1) start, (1,0) stop
  task automatic edge_mark(input logic first, input logic second);
    scl_clk = 1'b0;
    #3 host_pull = first;
    #3 scl_clk = 1'b1;
    #13 host_pull = second;
    #13;
  endtask : edge_mark

  // Byte out, MSB first, then the device acknowledge slot
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask : put_byte

  // Byte in; host acknowledges only when more bytes follow
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(~more, s);
  endtask : get_byte

  // Write n bytes, lowest byte of d first
  task automatic write_regs(input logic [6:0] addr, input logic [7:0] cmd,
                            input logic [23:0] d, input int n,
                            output logic ok);
    logic a;
    // Step off the core clock grid so both clocks stay unrelated
    #1.3;
    edge_mark(1'b0, 1'b1);
    put_byte({addr, 1'b0}, a);
    ok = a;
    if (a) begin
      put_byte(cmd, a);
      ok &= a;
      for (int i = 0; i < n; i++) begin
        put_byte(d[8*i +: 8], a);
        ok &= a;
      end
    end
    edge_mark(1'b1, 1'b0);
  endtask : write_regs

  // Read n bytes into d, lowest byte first
  task automatic read_regs(input logic [7:0] cmd, input int n,
                           output logic [23:0] d, output logic ok);
    logic       a;
    logic [7:0] b;
    d = 24'h000000;
    #1.3;
    edge_mark(1'b0, 1'b1);
    put_byte({gha_pkg::DEV_ADDR, 1'b0}, a);
    ok = a;
    put_byte(cmd, a);
    ok &= a;
    edge_mark(1'b0, 1'b1);
    put_byte({gha_pkg::DEV_ADDR, 1'b1}, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      get_byte(i < n - 1, b);
      d[8*i +: 8] = b;
    end
    edge_mark(1'b1, 1'b0);
  endtask : read_regs
endmodule : gha_host

//--- tb/tb_top.sv
// Purpose: Self-checking bench for line events and host register access
// Assumes: Host model runs the link in its own clock, unrelated to sys_clk
// Notes:   Pin changes land at the falling edge of sys_clk
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                      sys_clk;
  logic                      rstn;
  logic                      keypad_locked;
  logic [gha_pkg::LINES-1:0] lines;
  logic                      scl_clk;
  logic                      host_pull;
  wire                       sda;
  logic                      sda_out;
  logic                      sda_oe;
  logic                      int_n_out;
  logic                      int_n_oe;
  wire                       int_n;
  int                        n_fail;
  int                        n_tests;
  int                        seed;
  int                        cycles;
  logic                      ok;
  logic [23:0]               rd;
  logic [23:0]               rv;
  logic [7:0]                evs [4];

  // Wired levels with pull-ups on both open-drain lines
  assign sda   = ~host_pull & ~(sda_oe & ~sda_out);
  assign int_n = ~(int_n_oe & ~int_n_out);

  gha_core u_gha_core (
    .sys_clk            (sys_clk),
    .rstn               (rstn),
    .scl_clk            (scl_clk),
    .sda_in             (sda),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .general_input_line (lines),
    .keypad_locked      (keypad_locked),
    .int_n_out          (int_n_out),
    .int_n_oe           (int_n_oe)
  );

  gha_host u_gha_host (
    .scl_clk   (scl_clk),
    .host_pull (host_pull),
    .sda       (sda)
  );

  // Core clock, 4 ns period
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  // Hang guard; a full run takes well under a third of this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] cmd, input logic [23:0] d,
                    input int n);
    u_gha_host.write_regs(gha_pkg::DEV_ADDR, cmd, d, n, ok);
    chk1(ok, 1'b1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] cmd, input int n,
                        input logic [23:0] exp);
    u_gha_host.read_regs(cmd, n, rd, ok);
    chk1(ok, 1'b1);
    for (int i = 0; i < n; i++) chk8(rd[8*i +: 8], exp[8*i +: 8]);
  endtask : rd_chk

  // Pin change, then enough cycles for sync and recording
  task automatic pin(input int idx, input logic v);
    @(negedge sys_clk);
    lines[idx] = v;
    repeat (12) @(posedge sys_clk);
  endtask : pin

  // Event byte: press flag over code 97 plus line index
  function automatic logic [7:0] ev(input int line, input logic press);
    return {press, gha_pkg::CODE_BASE + 7'(line)};
  endfunction : ev

  initial begin
    seed          = 94;
    n_fail        = 0;
    n_tests       = 0;
    cycles        = 0;
    rstn          = 1'b0;
    keypad_locked = 1'b1;
    lines         = 18'h20000;
    evs           = '{ev(3, 1'b1), ev(3, 1'b0), ev(17, 1'b1), ev(17, 1'b0)};
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    // Random bank while locked, read back through the stepping pointer
    rv = 24'($random(seed));
    wr(gha_pkg::REG_ENROLL, rv, 3);
    rd_chk(gha_pkg::REG_ENROLL, 3, rv & gha_pkg::LINE_MASK);
    // Unmapped offset: acknowledged, dropped, reads zero
    wr(8'h30, rv, 1);
    rd_chk(8'h30, 1, 24'h000000);
    // Foreign address: no acknowledge and no effect
    u_gha_host.write_regs(gha_pkg::DEV_ADDR ^ 7'h01, gha_pkg::REG_SENSE,
                          24'hffffff, 3, ok);
    chk1(ok, 1'b0);
    rd_chk(gha_pkg::REG_SENSE, 3, 24'h000000);
    // Line 3 active high, line 17 active low, both enrolled
    wr(gha_pkg::REG_SENSE, 24'h000008, 3);
    wr(gha_pkg::REG_ENROLL, 24'h020008, 3);
    rd_chk(gha_pkg::REG_COUNT, 1, 24'h000000);
    @(negedge sys_clk);
    keypad_locked = 1'b0;
    pin(0, 1'b1);
    pin(0, 1'b0);
    pin(3, 1'b1);
    chk1(int_n, 1'b0);
    pin(3, 1'b0);
    pin(17, 1'b0);
    pin(17, 1'b1);
    // Random traffic on lines that are not enrolled
    for (int k = 0; k < 6; k++)
      pin(4 + ($unsigned($random(seed)) % 13), 1'($random(seed)));
    rd_chk(gha_pkg::REG_COUNT, 1, 24'h000004);
    for (int k = 0; k < 4; k++)
      rd_chk(gha_pkg::REG_EVENT, 1, {16'h0000, evs[k]});
    rd_chk(gha_pkg::REG_EVENT, 1, 24'h000000);
    // Nine edges into a table of eight: the ninth waits for space
    for (int k = 0; k < 9; k++) pin(3, ~lines[3]);
    rd_chk(gha_pkg::REG_COUNT, 1, {20'h00000, gha_pkg::DEPTH});
    for (int k = 0; k < 9; k++)
      rd_chk(gha_pkg::REG_EVENT, 1, {16'h0000, ev(3, k % 2 == 0)});
    rd_chk(gha_pkg::REG_COUNT, 1, 24'h000000);
    // Locked keypad drops enrolled line events
    @(negedge sys_clk);
    keypad_locked = 1'b1;
    pin(3, 1'b1);
    pin(3, 1'b0);
    rd_chk(gha_pkg::REG_COUNT, 1, 24'h000000);
    // Write one to the flag clears it and releases the interrupt
    rd_chk(gha_pkg::REG_STATUS, 1, 24'h000001);
    wr(gha_pkg::REG_STATUS, 24'h000001, 1);
    repeat (8) @(posedge sys_clk);
    chk1(int_n, 1'b1);
    rd_chk(gha_pkg::REG_STATUS, 1, 24'h000000);
    test_done();
  end
endmodule : tb_top
